// ===== dv/cfh_codec_model.sv
// codec core model streaming frames
`timescale 1ns/1ps
module cfh_codec_model (
   input wire logic clk_i,
   input wire logic bit_ready_i,
   output logic bit_valid_o,
   output logic bit_data_o,
   output logic bit_last_o
);
   initial begin
      bit_valid_o = 1'b0;
      bit_data_o = 1'b0;
      bit_last_o = 1'b0;
   end
   task automatic send(input logic [15:0] hdr, input int n, input bit slow);
      logic b;
      b = 1'b0;
      for (int i = 0; i < n; i++) begin
         b = (i < 16) ? hdr[15 - i] : i[0];
         bit_valid_o <= 1'b1;
         bit_data_o <= b;
         bit_last_o <= (i == n - 1);
         @(posedge clk_i);
         while (!bit_ready_i) @(posedge clk_i);
         if (slow) begin
            bit_valid_o <= 1'b0;
            bit_data_o <= ~b;
            @(posedge clk_i);
         end
      end
      bit_valid_o <= 1'b0;
      bit_data_o <= ~b;
      bit_last_o <= 1'b0;
   endtask
endmodule

// ===== dv/cfh_parser_monitor.sv
// checker of the parser result port
`timescale 1ns/1ps
module cfh_parser_monitor (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hdr_valid_o,
   input wire logic hdr_ready_i,
   input wire cfh_pkg::cfh_hdr_t hdr_o,
   input wire logic frame_invalid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_held;
      hdr_valid_o && !hdr_ready_i;
   endsequence
   sequence s_rate(cfh_pkg::cfh_rate_t r);
      hdr_valid_o && hdr_o.rate == r;
   endsequence
   property p_hold;
      s_held |=> hdr_valid_o && $stable(hdr_o) && $stable(frame_invalid_o);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed while held");
   property p_bad;
      frame_invalid_o |-> hdr_valid_o && hdr_o.rate == cfh_pkg::RATE_NONE && hdr_o.core == cfh_pkg::CORE_NONE;
   endproperty
   a_bad: assert property (p_bad) else $error("bad frame parsed");
   property p_vbr;
      s_rate(cfh_pkg::RATE_2K8) |-> hdr_o.frame_bits == 10'h038 && hdr_o.hdr_bits == 4'h3 && hdr_o.payload_bits == 10'h035;
   endproperty
   a_vbr: assert property (p_vbr) else $error("2.8 split wrong");
   property p_idle;
      s_rate(cfh_pkg::RATE_2K8) ##0 !hdr_o.active |-> hdr_o.core == cfh_pkg::CORE_NONE;
   endproperty
   a_idle: assert property (p_idle) else $error("inactive frame has core");
   property p_noext;
      hdr_valid_o && (hdr_o.rate == cfh_pkg::RATE_7K2 || hdr_o.rate == cfh_pkg::RATE_8K0) |-> hdr_o.ext == cfh_pkg::EXT_NONE;
   endproperty
   a_noext: assert property (p_noext) else $error("extension at low rate");
   property p_132;
      s_rate(cfh_pkg::RATE_13K2) |-> hdr_o.frame_bits == 10'h108 && hdr_o.hdr_bits >= 4'h5;
   endproperty
   a_132: assert property (p_132) else $error("13.2 header wrong");
   property p_164;
      s_rate(cfh_pkg::RATE_16K4) |-> hdr_o.frame_bits == 10'h148 && hdr_o.pad_bits == 2'h3;
   endproperty
   a_164: assert property (p_164) else $error("16.4 framing wrong");
   property p_244;
      s_rate(cfh_pkg::RATE_24K4) |-> hdr_o.frame_bits == 10'h1e8 && hdr_o.pad_bits == 2'h3;
   endproperty
   a_244: assert property (p_244) else $error("24.4 framing wrong");
   property p_sw;
      hdr_valid_o && hdr_o.rate16k |-> hdr_o.prev_lp && hdr_o.core == cfh_pkg::CORE_HQ;
   endproperty
   a_sw: assert property (p_sw) else $error("rate bit without lp");
endmodule
bind cfh_parser cfh_parser_monitor u_cfh_parser_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .hdr_valid_o(hdr_valid_o), .hdr_ready_i(hdr_ready_i), .hdr_o(hdr_o), .frame_invalid_o(frame_invalid_o));

// ===== dv/cfh_parser_tb.sv
// self-checking bench of the parser
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module cfh_parser_tb;
   logic clk_i, rst_b_i, bit_valid_i, bit_data_i, bit_last_i, hdr_ready_i, bit_ready_o, hdr_valid_o, frame_invalid_o;
   cfh_pkg::cfh_hdr_t hdr_o;
   int n_mismatch = 0;
   int samples_checked = 0;
   cfh_parser u_cfh_parser (.clk_i(clk_i), .rst_b_i(rst_b_i), .bit_valid_i(bit_valid_i), .bit_ready_o(bit_ready_o),
      .bit_data_i(bit_data_i), .bit_last_i(bit_last_i), .hdr_valid_o(hdr_valid_o), .hdr_ready_i(hdr_ready_i),
      .hdr_o(hdr_o), .frame_invalid_o(frame_invalid_o));
   cfh_codec_model u_cfh_codec_model (.clk_i(clk_i), .bit_ready_i(bit_ready_o), .bit_valid_o(bit_valid_i),
      .bit_data_o(bit_data_i), .bit_last_o(bit_last_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_hdr;
      int k;
      k = 0;
      while (hdr_valid_o !== 1'b1 && k < 40) begin
         @(negedge clk_i);
         k++;
      end
      `CHK(hdr_valid_o, 1'b1)
   endtask
   task automatic frame(input logic [15:0] h, input int n, input bit slow);
      u_cfh_codec_model.send(h, n, slow);
      wait_hdr;
   endtask
   task automatic accept(input string nm);
      @(posedge clk_i);
      hdr_ready_i <= 1'b1;
      @(posedge clk_i);
      hdr_ready_i <= 1'b0;
      $display("test %s done", nm);
   endtask
   task automatic rc(input cfh_pkg::cfh_rate_t r, input cfh_pkg::cfh_core_t c);
      `CHK(hdr_o.rate, r)
      `CHK(hdr_o.core, c)
   endtask
   task automatic t_vbr;
      frame(16'he000, 56, 1'b0);
      rc(cfh_pkg::RATE_2K8, cfh_pkg::CORE_NOISE_EXCITED_FRAME);
      `CHK(hdr_o.wideband, 1'b1)
      `CHK(hdr_o.payload_bits, 10'h035)
      accept("noise_excited_frame");
      frame(16'h8000, 56, 1'b1);
      rc(cfh_pkg::RATE_2K8, cfh_pkg::CORE_PPP);
      `CHK(hdr_o.wideband, 1'b0)
      accept("ppp");
      frame(16'h0000, 56, 1'b0);
      `CHK(hdr_o.active, 1'b0)
      accept("inactive");
   endtask
   task automatic t_low;
      frame(16'hc000, 144, 1'b0);
      rc(cfh_pkg::RATE_7K2, cfh_pkg::CORE_HQ);
      `CHK(hdr_o.ext, cfh_pkg::EXT_NONE)
      accept("7k2");
      frame(16'h3000, 160, 1'b0);
      rc(cfh_pkg::RATE_8K0, cfh_pkg::CORE_LP);
      accept("8k0");
      frame(16'h7800, 192, 1'b0);
      rc(cfh_pkg::RATE_9K6, cfh_pkg::CORE_TCX);
      `CHK(hdr_o.coder_type_field, 4'h7)
      accept("9k6 tcx");
      frame(16'h0800, 192, 1'b1);
      rc(cfh_pkg::RATE_9K6, cfh_pkg::CORE_LP);
      accept("9k6 lp");
   endtask
   task automatic t_132;
      frame(16'hc600, 264, 1'b0);
      rc(cfh_pkg::RATE_13K2, cfh_pkg::CORE_TCX);
      `CHK(hdr_o.joint_index, 5'h18)
      `CHK(hdr_o.transform_coder_type_field, 2'h2)
      accept("13k2 tcx");
      frame(16'h4400, 264, 1'b0);
      rc(cfh_pkg::RATE_13K2, cfh_pkg::CORE_LP);
      `CHK(hdr_o.ext, cfh_pkg::EXT_FD)
      accept("13k2 lp");
   endtask
   task automatic t_high;
      frame(16'hd600, 328, 1'b0);
      rc(cfh_pkg::RATE_16K4, cfh_pkg::CORE_HQ);
      `CHK(hdr_o.prev_lp, 1'b1)
      `CHK(hdr_o.rate16k, 1'b1)
      accept("16k4 hq");
      frame(16'hc000, 328, 1'b0);
      rc(cfh_pkg::RATE_16K4, cfh_pkg::CORE_LP);
      accept("16k4 lp");
      frame(16'hba00, 488, 1'b0);
      rc(cfh_pkg::RATE_24K4, cfh_pkg::CORE_TCX);
      `CHK(hdr_o.transform_coder_type_field, 2'h1)
      `CHK(hdr_o.bandwidth_field, 2'h2)
      `CHK(hdr_o.reserved, 1'b1)
      accept("24k4 tcx");
   endtask
   task automatic t_bad;
      frame(16'hffff, 100, 1'b0);
      `CHK(frame_invalid_o, 1'b1)
      rc(cfh_pkg::RATE_NONE, cfh_pkg::CORE_NONE);
      `CHK(hdr_o.frame_bits, 10'h064)
      accept("bad length");
   endtask
   task automatic t_backpressure;
      frame(16'he000, 56, 1'b0);
      @(posedge clk_i);
      fork
         u_cfh_codec_model.send(16'hc000, 144, 1'b0);
         begin
            repeat (20) @(negedge clk_i);
            `CHK(bit_ready_o, 1'b0)
            `CHK(hdr_o.rate, cfh_pkg::RATE_2K8)
            accept("held");
         end
      join
      wait_hdr;
      `CHK(hdr_o.rate, cfh_pkg::RATE_7K2)
      `CHK(bit_ready_o, 1'b1)
      accept("after stall");
   endtask
   initial begin
      rst_b_i = 1'b0;
      hdr_ready_i = 1'b0;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_vbr;
      t_low;
      t_132;
      t_high;
      t_bad;
      t_backpressure;
      close_out;
   end
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
endmodule

// ===== hdl/cfh_bit_capture.sv
// frame length counter and leading header bit capture
`timescale 1ns/1ps
module cfh_bit_capture (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clr_i,
   input wire logic en_i,
   input wire logic bit_i,
   output logic [9:0] len_o,
   output logic [15:0] hdr_o,
   output logic over_o
);
   typedef struct packed {
      logic [9:0] len;
      logic [15:0] hdr;
      logic over;
   } cfh_cap_t;
   cfh_cap_t st_reg;
   cfh_cap_t st_next;

   always_comb begin
      st_next = st_reg;
      if (clr_i) begin
         st_next.len = cfh_pkg::LEN_RESET;
         st_next.hdr = cfh_pkg::HDR_RESET;
         st_next.over = 1'b0;
      end
      if (en_i) begin
         // first bit lands at hdr[15], most significant first (see R1)
         if (st_next.len < 10'h010) begin
            st_next.hdr[4'hf - st_next.len[3:0]] = bit_i;
         end
         if (st_next.len == cfh_pkg::LEN_MAX) begin
            st_next.over = 1'b1;
         end else begin
            st_next.len = st_next.len + 10'h001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign len_o = st_reg.len;
   assign hdr_o = st_reg.hdr;
   assign over_o = st_reg.over;
endmodule

// ===== hdl/cfh_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module cfh_fifo #(
   parameter int unsigned W = 2,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
   assign out_valid_o = (cnt_reg != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_reg];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== hdl/cfh_parser.sv
// codec frame header parser top
// Notes on behaviour
// R1: fields arrive most significant bit first; first frame bit is header bit 15.
// R2: variable rate uses prototype pitch, noise excited, 7.2 and 8.0 frames.
// R3: 2.8 frames: active flag bit, then two bits give band and frame type.
// R4: 56 bit frames hold 3 coder type bits then 53 core bits.
// R5: 7.2 and 8.0 carry a joint index that also picks lp or hq core.
// R6: 7.2 and 8.0 frames carry no extension layer.
// R7: 9.6 core choice is coded inside the coder type field.
// R8: 264 bit frames start with a 5 bit joint index choosing core family.
// R9: 13.2 transform: one bit picks hq or tcx; tcx adds 2 type bits.
// R10: 13.2 lp with extension: one flag picks time or frequency extension.
// R11: 328 bit frames: 2 bandwidth bits, reserved bit, 3 padding bits.
// R12: 488 bit frames: bandwidth, reserved, 2 bit coder type, 3 padding bits.
// R13: at 16.4 and 24.4 one core flag picks lp or transform cores.
// R14: after transform flag the next bit picks hq or tcx core.
// R15: tcx at these rates: the remaining two bits give transform coder type.
// R16: hq core: one or two further bits flag previous lp frame.
// R17: second switching bit only after lp frame; gives 12.8 or 16 kHz.
// R18: length identifies rate; unknown lengths flagged invalid, fields not parsed.
`timescale 1ns/1ps
module cfh_parser (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic bit_valid_i,
   output logic bit_ready_o,
   input wire logic bit_data_i,
   input wire logic bit_last_i,
   output logic hdr_valid_o,
   input wire logic hdr_ready_i,
   output cfh_pkg::cfh_hdr_t hdr_o,
   output logic frame_invalid_o
);
   typedef enum logic [1:0] {
      ST_COLLECT, ST_DECODE, ST_HOLD
   } cfh_state_t;

   typedef struct packed {
      cfh_state_t state;
      cfh_pkg::cfh_hdr_t hdr;
      logic invalid;
      logic clr;
   } cfh_top_t;

   cfh_top_t st_reg;
   cfh_top_t st_next;

   cfh_pkg::cfh_bit_t fifo_in;
   cfh_pkg::cfh_bit_t fifo_out;
   logic fifo_valid;
   logic fifo_pop;
   logic [9:0] cap_len;
   logic [15:0] h;
   logic cap_over;
   cfh_pkg::cfh_hdr_t dec;
   logic dec_bad;

   assign fifo_in.last = bit_last_i;
   assign fifo_in.data = bit_data_i;
   // bits drain only while collecting, so a held result stalls the source
   assign fifo_pop = fifo_valid && (st_reg.state == ST_COLLECT);

   cfh_fifo #(
      .W(cfh_pkg::FIFO_W),
      .DEPTH(cfh_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(bit_valid_i),
      .in_ready_o(bit_ready_o),
      .in_data_i(fifo_in),
      .out_valid_o(fifo_valid),
      .out_ready_i(st_reg.state == ST_COLLECT),
      .out_data_o(fifo_out)
   );

   cfh_bit_capture u_cap (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .clr_i(st_reg.clr),
      .en_i(fifo_pop),
      .bit_i(fifo_out.data),
      .len_o(cap_len),
      .hdr_o(h),
      .over_o(cap_over)
   );

   // header decode from captured length and leading bits
   always_comb begin
      dec = '0;
      dec_bad = 1'b0;
      dec.frame_bits = cap_len;
      case (cap_len) // see R18
         cfh_pkg::LEN_2K8: begin
            // see R2
            dec.rate = cfh_pkg::RATE_2K8;
            dec.hdr_bits = cfh_pkg::HB_2K8; // see R4
            dec.coder_type_field = {1'b0, h[15:13]};
            dec.active = h[15]; // see R3
            if (h[15]) begin
               dec.core = h[14] ? cfh_pkg::CORE_NOISE_EXCITED_FRAME : cfh_pkg::CORE_PPP; // see R3
               dec.wideband = h[13];
            end
         end
         cfh_pkg::LEN_7K2, cfh_pkg::LEN_8K0: begin
            dec.rate = (cap_len == cfh_pkg::LEN_7K2) ? cfh_pkg::RATE_7K2 : cfh_pkg::RATE_8K0; // see R2
            dec.hdr_bits = cfh_pkg::HB_JOINT8;
            dec.joint_index = {1'b0, h[15:12]}; // see R5
            dec.active = 1'b1;
            dec.core = (h[15:12] >= cfh_pkg::J8_HQ_MIN) ? cfh_pkg::CORE_HQ : cfh_pkg::CORE_LP; // see R5
            dec.ext = cfh_pkg::EXT_NONE; // see R6
         end
         cfh_pkg::LEN_9K6: begin
            dec.rate = cfh_pkg::RATE_9K6;
            dec.hdr_bits = cfh_pkg::HB_9K6;
            dec.active = 1'b1;
            dec.bandwidth_field = h[15:14];
            dec.coder_type_field = {1'b0, h[13:11]};
            if (h[13:11] == cfh_pkg::CT96_TCX) begin // see R7
               dec.core = cfh_pkg::CORE_TCX;
               dec.ext = cfh_pkg::EXT_GAP;
            end else begin
               dec.core = cfh_pkg::CORE_LP;
               dec.ext = cfh_pkg::EXT_TD;
            end
         end
         cfh_pkg::LEN_13K2: begin
            dec.rate = cfh_pkg::RATE_13K2;
            dec.active = 1'b1;
            dec.joint_index = h[15:11]; // see R8
            if (h[15:11] >= cfh_pkg::J13_MDCT_MIN) begin
               if (h[10]) begin // see R9
                  dec.core = cfh_pkg::CORE_TCX;
                  dec.transform_coder_type_field = h[9:8]; // see R9
                  dec.hdr_bits = cfh_pkg::HB_13K2 + 4'h3;
               end else begin
                  dec.core = cfh_pkg::CORE_HQ;
                  dec.hdr_bits = cfh_pkg::HB_13K2 + 4'h1;
               end
            end else if (h[15:11] >= cfh_pkg::J13_EXT_MIN) begin
               dec.core = cfh_pkg::CORE_LP;
               dec.ext = h[10] ? cfh_pkg::EXT_FD : cfh_pkg::EXT_TD; // see R10
               dec.hdr_bits = cfh_pkg::HB_13K2 + 4'h1;
            end else begin
               dec.core = cfh_pkg::CORE_LP;
               dec.hdr_bits = cfh_pkg::HB_13K2;
            end
         end
         cfh_pkg::LEN_16K4, cfh_pkg::LEN_24K4: begin
            dec.rate = (cap_len == cfh_pkg::LEN_16K4) ? cfh_pkg::RATE_16K4 : cfh_pkg::RATE_24K4;
            dec.active = 1'b1;
            dec.bandwidth_field = h[15:14]; // see R11
            dec.reserved = h[13]; // see R12
            dec.pad_bits = cfh_pkg::PAD_HIGH; // see R11
            if (!h[12]) begin // see R13
               dec.core = cfh_pkg::CORE_LP;
               if (cap_len == cfh_pkg::LEN_16K4) begin
                  dec.coder_type_field = {1'b0, h[11:9]};
                  dec.hdr_bits = cfh_pkg::HB_HIGH + 4'h3;
               end else begin
                  dec.coder_type_field = {2'b00, h[11:10]}; // see R12
                  dec.hdr_bits = cfh_pkg::HB_HIGH + 4'h2;
               end
               dec.ext = (h[15:14] >= 2'h2) ? cfh_pkg::EXT_TD : cfh_pkg::EXT_NONE;
            end else if (h[11]) begin // see R14
               dec.core = cfh_pkg::CORE_TCX;
               dec.transform_coder_type_field = h[10:9]; // see R15
               dec.hdr_bits = cfh_pkg::HB_HIGH + 4'h3;
               dec.ext = (h[15:14] >= 2'h2) ? cfh_pkg::EXT_GAP : cfh_pkg::EXT_NONE;
            end else begin
               dec.core = cfh_pkg::CORE_HQ;
               dec.prev_lp = h[10]; // see R16
               if (h[10]) begin
                  dec.rate16k = h[9]; // see R17
                  dec.hdr_bits = cfh_pkg::HB_HIGH + 4'h3;
               end else begin
                  dec.hdr_bits = cfh_pkg::HB_HIGH + 4'h2; // see R17
               end
            end
         end
         default: begin
            dec_bad = 1'b1;
         end
      endcase
      if (cap_over) begin
         dec_bad = 1'b1;
      end
      if (dec_bad) begin
         // fields other than frame_bits stay zero for a frame of unknown length (see R18)
         dec = '0;
         dec.frame_bits = cap_len;
      end else begin
         dec.payload_bits = cap_len - {6'h00, dec.hdr_bits} - {8'h00, dec.pad_bits};
      end
   end

   // frame sequencing
   always_comb begin
      st_next = st_reg;
      st_next.clr = 1'b0;
      case (st_reg.state)
         ST_COLLECT: begin
            if (fifo_pop && fifo_out.last) begin
               st_next.state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            st_next.hdr = dec;
            st_next.invalid = dec_bad; // see R18
            st_next.state = ST_HOLD;
         end
         ST_HOLD: begin
            if (hdr_ready_i) begin
               st_next.clr = 1'b1;
               st_next.invalid = 1'b0; // see R18
               st_next.state = ST_COLLECT;
            end
         end
         default: begin
            st_next.state = ST_COLLECT;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hdr_valid_o = (st_reg.state == ST_HOLD);
   assign hdr_o = st_reg.hdr;
   assign frame_invalid_o = st_reg.invalid;
endmodule

// ===== hdl/cfh_pkg.sv
// constants and types for the codec frame header parser
package cfh_pkg;
   localparam int unsigned LEN_W = 10;
   localparam int unsigned HDR_W = 16;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_W = 2;
   // frame lengths in bits
   localparam logic [9:0] LEN_2K8 = 10'h038;
   localparam logic [9:0] LEN_7K2 = 10'h090;
   localparam logic [9:0] LEN_8K0 = 10'h0a0;
   localparam logic [9:0] LEN_9K6 = 10'h0c0;
   localparam logic [9:0] LEN_13K2 = 10'h108;
   localparam logic [9:0] LEN_16K4 = 10'h148;
   localparam logic [9:0] LEN_24K4 = 10'h1e8;
   localparam logic [9:0] LEN_MAX = 10'h3ff;
   // header field widths and padding
   localparam logic [3:0] HB_2K8 = 4'h3;
   localparam logic [3:0] HB_JOINT8 = 4'h4;
   localparam logic [3:0] HB_9K6 = 4'h5;
   localparam logic [3:0] HB_13K2 = 4'h5;
   localparam logic [3:0] HB_HIGH = 4'h4;
   localparam logic [1:0] PAD_HIGH = 2'h3;
   // joint index and coder type code points
   localparam logic [3:0] J8_HQ_MIN = 4'hc;
   localparam logic [2:0] CT96_TCX = 3'h7;
   localparam logic [4:0] J13_EXT_MIN = 5'h08;
   localparam logic [4:0] J13_MDCT_MIN = 5'h18;
   localparam logic [9:0] LEN_RESET = 10'h000;
   localparam logic [15:0] HDR_RESET = 16'h0000;

   typedef enum logic [2:0] {
      RATE_NONE, RATE_2K8, RATE_7K2, RATE_8K0, RATE_9K6, RATE_13K2, RATE_16K4, RATE_24K4
   } cfh_rate_t;

   typedef enum logic [2:0] {
      CORE_NONE, CORE_LP, CORE_HQ, CORE_TCX, CORE_PPP, CORE_NOISE_EXCITED_FRAME
   } cfh_core_t;

   typedef enum logic [1:0] {
      EXT_NONE, EXT_TD, EXT_FD, EXT_GAP
   } cfh_ext_t;

   typedef struct packed {
      logic last;
      logic data;
   } cfh_bit_t;

   typedef struct packed {
      cfh_rate_t rate;
      cfh_core_t core;
      cfh_ext_t ext;
      logic [1:0] bandwidth_field;
      logic [3:0] coder_type_field;
      logic [4:0] joint_index;
      logic [1:0] transform_coder_type_field;
      logic active;
      logic wideband;
      logic reserved;
      logic prev_lp;
      logic rate16k;
      logic [3:0] hdr_bits;
      logic [1:0] pad_bits;
      logic [9:0] frame_bits;
      logic [9:0] payload_bits;
   } cfh_hdr_t;
endpackage
